// file: shared/metering_irq_pkg.sv
// Purpose: Shared constants for the low interrupt mask block.
// Assumes: Byte addresses on an 8-bit register port, 32-bit data.
// Notes: Status and mask share one bit layout.
package metering_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PAGE_SEL = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_ENERGY_CFG = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_PULSE_SIGN = 8'h10;

  // Counts
  localparam int MASK_W = 18;
  localparam int PAGE_COUNT = 16;
  localparam int PULSE_COUNT = 4;
  localparam int PHASE_COUNT = 3;
  localparam int INTERVAL_W = 13;

  // Bit positions in mask and status
  localparam int BIT_ENERGY_UPDATE = 0;
  localparam int BIT_ACTIVE_LO = 1;
  localparam int BIT_REACTIVE_LO = 4;
  localparam int BIT_PULSE_SIGN_LO = 7;
  localparam int BIT_PULSE_LO = 11;
  localparam int BIT_SAMPLE_READY = 15;
  localparam int BIT_CAPTURE_STOP = 16;
  localparam int BIT_PAGE_FULL = 17;

  // Energy configuration fields
  localparam int CFG_INTERVAL_LO = 0;
  localparam int CFG_MODE_BIT = 16;

  // Values after reset
  localparam logic [MASK_W-1:0] MASK_RESET = 18'h00000;
  localparam logic [MASK_W-1:0] STATUS_RESET = 18'h00000;
  localparam logic [PAGE_COUNT-1:0] PAGE_SEL_RESET = 16'h0000;
  localparam logic [INTERVAL_W-1:0] INTERVAL_RESET = 13'h0000;
  localparam logic TIMER_MODE_RESET = 1'b0;
  localparam logic [PULSE_COUNT-1:0] PULSE_SIGN_RESET = 4'h0;

  typedef enum logic {
    TIMER_SAMPLES,
    TIMER_LINE_CYCLES
  } timer_mode_t;

endpackage

// file: tb/metering_irq_mask_low_asserts.sv
// Purpose: Port-level checks of the low interrupt mask block.
// Assumes: One clock, synchronous active-high reset.
// Notes: A shadow of the mask follows host writes.
module metering_irq_mask_low_asserts
  import metering_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  input wire logic [DATA_W-1:0] readData,
  input wire logic [PAGE_COUNT-1:0] pageFilled,
  input wire logic captureStopped,
  input wire logic samplesReady,
  input wire logic [PULSE_COUNT-1:0] energyPulsePin,
  input wire logic [PULSE_COUNT-1:0] pulseEnergySign,
  input wire logic [PHASE_COUNT-1:0] activePowerSign,
  input wire logic [PHASE_COUNT-1:0] reactivePowerSign,
  input wire logic sampleTick,
  input wire logic lineCycleTick,
  input wire logic irqRequest,
  input wire logic energyUpdate
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [MASK_W-1:0] maskSh;
  logic maskWr;
  assign maskWr = writeStrobe && address == ADDR_MASK;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      maskSh <= MASK_RESET;
    end else if (maskWr) begin
      maskSh <= writeData[MASK_W-1:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Pin path needs the mask steady through the sync delay
  sequence pinFall1;
    $fell(energyPulsePin[0]) && maskSh[BIT_PULSE_LO] && !maskWr;
  endsequence
  sequence noMaskWr3;
    !maskWr [*3];
  endsequence
  quiet_mask_a: assert property (
    maskSh == '0 |=> !irqRequest) else $error("irq with mask clear");
  rose_cause_a: assert property (
    $rose(irqRequest) |-> $past(maskSh) != '0) else $error("irq cause");
  irq_drop_a: assert property (
    maskWr && writeData[MASK_W-1:0] == '0 |-> ##2 !irqRequest)
    else $error("irq kept");
  mask_read_a: assert property (
    readStrobe && address == ADDR_MASK |=> readData == 32'(maskSh))
    else $error("mask read");
  cap_stop_a: assert property (
    captureStopped && maskSh[BIT_CAPTURE_STOP] && !maskWr
    |-> ##2 irqRequest) else $error("capture irq");
  sample_ready_a: assert property (
    samplesReady && maskSh[BIT_SAMPLE_READY] && !maskWr
    |-> ##2 irqRequest) else $error("samples irq");
  energy_irq_a: assert property (
    energyUpdate && maskSh[BIT_ENERGY_UPDATE] |=> irqRequest)
    else $error("energy irq");
  pulse_fall_a: assert property (
    pinFall1 ##1 noMaskWr3 |-> ##[1:3] irqRequest) else $error("pin irq");
endmodule

bind metering_irq_mask_low metering_irq_mask_low_asserts chk (.clk_sys,
  .reset, .address, .writeData, .writeStrobe, .readStrobe, .readData,
  .pageFilled, .captureStopped, .samplesReady, .energyPulsePin,
  .pulseEnergySign, .activePowerSign, .reactivePowerSign, .sampleTick,
  .lineCycleTick, .irqRequest, .energyUpdate);

// file: tb/metering_irq_mask_low_tb_top.sv
// Purpose: Self-checking bench for the low interrupt mask block.
// Assumes: Interval 0 fires on every chosen tick.
// Notes: Each row drives one source, then clears its flags.
module metering_irq_mask_low_tb_top
  import metering_irq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, reset = 1'h1;
  logic writeStrobe = 1'h0, readStrobe = 1'h0;
  logic [ADDR_W-1:0] address = '0;
  logic [DATA_W-1:0] writeData = '0, readData;
  logic [PAGE_COUNT-1:0] pageFilled = '0;
  logic captureStopped = 1'h0, samplesReady = 1'h0;
  logic sampleTick = 1'h0, lineCycleTick = 1'h0;
  logic [PULSE_COUNT-1:0] energyPulsePin = 4'hF, pulseEnergySign = 4'hF;
  logic [PHASE_COUNT-1:0] activePowerSign = '0, reactivePowerSign = '0;
  logic irqRequest, energyUpdate;
  int miscompares = 0, nChecks = 0, euCount = 0;
  // Row i drives source i; value is the status it must leave
  localparam logic [MASK_W-1:0] EXP [14] = '{18'h00001,
    18'h00002, 18'h00004, 18'h00008,
    18'h00010, 18'h00020, 18'h00040,
    18'h00880, 18'h01100, 18'h02200, 18'h04400,
    18'h08000, 18'h10000, 18'h20000};

  metering_irq_mask_low dut (.clk_sys, .reset, .address, .writeData,
    .writeStrobe, .readStrobe, .readData, .pageFilled, .captureStopped,
    .samplesReady, .energyPulsePin, .pulseEnergySign, .activePowerSign,
    .reactivePowerSign, .sampleTick, .lineCycleTick, .irqRequest,
    .energyUpdate);

  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (energyUpdate === 1'h1) euCount++;

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    nChecks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'h1;
    @(posedge clk_sys);
    writeStrobe <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    address <= a;
    readStrobe <= 1'h1;
    @(posedge clk_sys);
    readStrobe <= 1'h0;
    @(negedge clk_sys);
    chk(readData, e);
  endtask

  // Pulses last one cycle; pins drop for one cycle only
  task automatic stim(input int i);
    @(posedge clk_sys);
    case (i)
      0: sampleTick <= 1'h1;
      1, 2, 3: activePowerSign[i-1] <= ~activePowerSign[i-1];
      4, 5, 6: reactivePowerSign[i-4] <= ~reactivePowerSign[i-4];
      7, 8, 9, 10: energyPulsePin[i-7] <= 1'h0;
      11: samplesReady <= 1'h1;
      12: captureStopped <= 1'h1;
      13: pageFilled[0] <= 1'h1;
      default: lineCycleTick <= 1'h1;
    endcase
    @(posedge clk_sys);
    {sampleTick, lineCycleTick, samplesReady, captureStopped} <= 4'h0;
    pageFilled <= '0;
    energyPulsePin <= 4'hF;
  endtask

  task automatic waitIrq(input logic v);
    int n;
    n = 0;
    @(negedge clk_sys);
    while (irqRequest !== v && n < 12) begin
      @(negedge clk_sys);
      n++;
    end
    if (irqRequest !== v) begin
      miscompares++;
      $display("CHECK FAILED %0t irq wait", $time);
      give_verdict();
    end else begin
      chk(32'(irqRequest), 32'(v));
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'h0;
    wr(ADDR_PAGE_SEL, 32'h00000001);
    wr(ADDR_ENERGY_CFG, 32'h00000000);
    for (int i = 0; i < 14; i++) begin
      wr(ADDR_MASK, 32'(EXP[i]));
      stim(i);
      waitIrq(1'h1);
      rd(ADDR_STATUS, 32'(EXP[i]));
      wr(ADDR_STATUS, 32'(EXP[i]));
      waitIrq(1'h0);
    end
    rd(ADDR_PULSE_SIGN, 32'h0000000F);
    wr(ADDR_MASK, 32'h00000000);
    pulseEnergySign <= 4'hE;
    stim(7);
    repeat (6) @(negedge clk_sys);
    chk(32'(irqRequest), 32'h00000000);
    rd(ADDR_STATUS, 32'h00000880);
    rd(ADDR_PULSE_SIGN, 32'h0000000E);
    wr(ADDR_MASK, 32'h00000080);
    waitIrq(1'h1);
    wr(ADDR_STATUS, 32'h00000880);
    wr(ADDR_ENERGY_CFG, 32'h00010002);
    euCount = 0;
    repeat (6) stim(0);
    repeat (6) stim(14);
    repeat (2) @(negedge clk_sys);
    chk(32'(euCount), 32'h00000002);
    // Unselected page must not flag; a set beside its own clear wins
    @(posedge clk_sys);
    pageFilled <= 16'h0002;
    @(posedge clk_sys);
    pageFilled <= '0;
    address <= ADDR_STATUS;
    writeData <= 32'h00008000;
    writeStrobe <= 1'h1;
    samplesReady <= 1'h1;
    @(posedge clk_sys);
    writeStrobe <= 1'h0;
    samplesReady <= 1'h0;
    rd(ADDR_STATUS, 32'h00008001);
    wr(8'h14, 32'hFFFFFFFF);
    rd(8'h14, 32'h00000000);
    wr(ADDR_MASK, 32'hFFFFFFFF);
    rd(ADDR_MASK, 32'h0003FFFF);
    waitIrq(1'h1);
    @(posedge clk_sys);
    reset <= 1'h1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'h0;
    @(negedge clk_sys);
    chk(32'(irqRequest), 32'h00000000);
    rd(ADDR_MASK, 32'h00000000);
    give_verdict();
  end
endmodule

// file: verilog/metering_irq_mask_low.sv
// Purpose: Low eighteen interrupt enables with their event flags.
// Assumes: Event strobes and sign levels come from logic on clk_sys;
//   energy pulse pins are asynchronous and are synchronised here.
// Notes: Interrupt output lags a flag or mask change by one cycle.
// Function
// - Mask bit 17 enables interrupt on fill of a selected buffer page.
// - Mask bit 16 enables interrupt when capture stops after a trigger.
// - Mask bit 15 enables interrupt when new waveform samples are ready.
// - Mask bits 14..11 enable interrupts on falling pulse pins 4..1.
// - Mask bits 10..7 enable interrupts on pulse polarity changes 4..1.
// - Mask bits 6..4 enable reactive power sign change, phases C..A.
// - Mask bits 3..1 enable active power sign change, phases C..A.
// - Mask bit 0 enables interrupt on energy update after set tick count.
// - Latest pulse sign per output is stored at each falling pin edge.
//
// Local design decisions: the placing of the registers and strobed register access.
module metering_irq_mask_low
  import metering_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [DATA_W-1:0] readData,
  input wire logic [PAGE_COUNT-1:0] pageFilled,
  input wire logic captureStopped,
  input wire logic samplesReady,
  input wire logic [PULSE_COUNT-1:0] energyPulsePin,
  input wire logic [PULSE_COUNT-1:0] pulseEnergySign,
  input wire logic [PHASE_COUNT-1:0] activePowerSign,
  input wire logic [PHASE_COUNT-1:0] reactivePowerSign,
  input wire logic sampleTick,
  input wire logic lineCycleTick,
  output logic irqRequest,
  output logic energyUpdate
);

  typedef struct packed {
    logic [MASK_W-1:0] mask;
    logic [PAGE_COUNT-1:0] pageSelect;
    logic [INTERVAL_W-1:0] interval;
    timer_mode_t timerMode;
    logic [INTERVAL_W-1:0] tickCount;
    logic [PULSE_COUNT-1:0] pulseSign;
    logic [PHASE_COUNT-1:0] activeSeen;
    logic [PHASE_COUNT-1:0] reactiveSeen;
    logic primed;
    logic energyUpdate;
    logic irqRequest;
    logic [DATA_W-1:0] readData;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;

  logic [PULSE_COUNT-1:0] pulseFall;
  logic [MASK_W-1:0] status;
  logic [MASK_W-1:0] events;
  logic statusClear;
  logic [PULSE_COUNT-1:0] signChange;
  logic chosenTick;
  logic intervalDone;

  pin_fall_detect pulse_pins (
    .clk_sys(clk_sys),
    .reset(reset),
    .pinLevel(energyPulsePin),
    .pinFall(pulseFall)
  );

  sticky_status_bank flags (
    .clk_sys(clk_sys),
    .reset(reset),
    .setEvents(events),
    .clearWrite(statusClear),
    .clearBits(writeData[MASK_W-1:0]),
    .status(status)
  );

  assign statusClear = writeStrobe && (address == ADDR_STATUS);

  // Tick source follows the timer unit select
  assign chosenTick = (state_reg.timerMode == TIMER_LINE_CYCLES) ?
                      lineCycleTick : sampleTick;
  // Update after interval+1 ticks, so a zero interval still counts one
  assign intervalDone = chosenTick &&
                        (state_reg.tickCount >= state_reg.interval);

  // A sign differing from the stored one at a pulse edge is a reversal
  assign signChange = pulseFall &
                      (pulseEnergySign ^ state_reg.pulseSign);

  always_comb begin
    events = '0;
    events[BIT_PAGE_FULL] = |(pageFilled & state_reg.pageSelect);
    events[BIT_CAPTURE_STOP] = captureStopped;
    events[BIT_SAMPLE_READY] = samplesReady;
    events[BIT_PULSE_LO +: PULSE_COUNT] = pulseFall;
    events[BIT_PULSE_SIGN_LO +: PULSE_COUNT] = signChange;
    // Held off until the first sign sample so reset gives no false event
    if (state_reg.primed) begin
      events[BIT_REACTIVE_LO +: PHASE_COUNT] =
        reactivePowerSign ^ state_reg.reactiveSeen;
      events[BIT_ACTIVE_LO +: PHASE_COUNT] =
        activePowerSign ^ state_reg.activeSeen;
    end
    events[BIT_ENERGY_UPDATE] = intervalDone;
  end

  always_comb begin
    state_next = state_reg;
    state_next.primed = 1'b1;
    state_next.activeSeen = activePowerSign;
    state_next.reactiveSeen = reactivePowerSign;
    state_next.energyUpdate = intervalDone;
    // Latest pulse sign, updated only at a falling pin edge
    for (int i = 0; i < PULSE_COUNT; i++) begin
      if (pulseFall[i]) begin
        state_next.pulseSign[i] = pulseEnergySign[i];
      end
    end
    if (chosenTick) begin
      if (intervalDone) begin
        state_next.tickCount = '0;
      end else begin
        state_next.tickCount = state_reg.tickCount + 1'b1;
      end
    end
    if (writeStrobe) begin
      unique case (address)
        ADDR_MASK: begin
          state_next.mask = writeData[MASK_W-1:0];
        end
        ADDR_PAGE_SEL: begin
          state_next.pageSelect = writeData[PAGE_COUNT-1:0];
        end
        ADDR_ENERGY_CFG: begin
          state_next.interval =
            writeData[CFG_INTERVAL_LO +: INTERVAL_W];
          state_next.timerMode = timer_mode_t'(writeData[CFG_MODE_BIT]);
          // New interval starts a fresh count
          state_next.tickCount = '0;
        end
        default: begin
        end
      endcase
    end
    state_next.readData = '0;
    if (readStrobe) begin
      unique case (address)
        ADDR_MASK: begin
          state_next.readData[MASK_W-1:0] = state_reg.mask;
        end
        ADDR_STATUS: begin
          state_next.readData[MASK_W-1:0] = status;
        end
        ADDR_PAGE_SEL: begin
          state_next.readData[PAGE_COUNT-1:0] = state_reg.pageSelect;
        end
        ADDR_ENERGY_CFG: begin
          state_next.readData[CFG_INTERVAL_LO +: INTERVAL_W] =
            state_reg.interval;
          state_next.readData[CFG_MODE_BIT] = state_reg.timerMode;
        end
        ADDR_PULSE_SIGN: begin
          state_next.readData[PULSE_COUNT-1:0] = state_reg.pulseSign;
        end
        default: begin
        end
      endcase
    end
    // A cleared mask bit keeps its flag away from the request
    state_next.irqRequest = |(status & state_reg.mask);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.mask <= MASK_RESET;
      state_reg.pageSelect <= PAGE_SEL_RESET;
      state_reg.interval <= INTERVAL_RESET;
      state_reg.timerMode <= timer_mode_t'(TIMER_MODE_RESET);
      state_reg.pulseSign <= PULSE_SIGN_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign readData = state_reg.readData;
  assign irqRequest = state_reg.irqRequest;
  assign energyUpdate = state_reg.energyUpdate;

endmodule

// file: verilog/pin_fall_detect.sv
// Purpose: Two-stage synchroniser and high-to-low detect on pulse pins.
// Assumes: Pins may change at any time relative to clk_sys.
// Notes: Fall output is one cycle long, from flops only.
module pin_fall_detect
  import metering_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [PULSE_COUNT-1:0] pinLevel,
  output logic [PULSE_COUNT-1:0] pinFall
);

  typedef struct packed {
    logic [PULSE_COUNT-1:0] stage1;
    logic [PULSE_COUNT-1:0] stage2;
    logic [PULSE_COUNT-1:0] prev;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage1 = pinLevel;
    state_next.stage2 = state_reg.stage1;
    state_next.prev = state_reg.stage2;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Prev resets low so an idle-high pin gives no false edge at start
  assign pinFall = state_reg.prev & ~state_reg.stage2;

endmodule

// file: verilog/sticky_status_bank.sv
// Purpose: Sticky event flags, cleared by writing ones.
// Assumes: Events are one-cycle pulses on clk_sys.
// Notes: A set in the clearing cycle wins over the clear.
module sticky_status_bank
  import metering_irq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [MASK_W-1:0] setEvents,
  input wire logic clearWrite,
  input wire logic [MASK_W-1:0] clearBits,
  output logic [MASK_W-1:0] status
);

  typedef struct packed {
    logic [MASK_W-1:0] flags;
  } status_state_t;

  status_state_t state_reg;
  status_state_t state_next;

  always_comb begin
    state_next = state_reg;
    if (clearWrite) begin
      state_next.flags = state_reg.flags & ~clearBits;
    end
    state_next.flags = state_next.flags | setEvents;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg.flags <= STATUS_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign status = state_reg.flags;

endmodule
